// ### pkg/ppc_map.svh
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH
// Offsets inside the I/O register space.
`define PPC_OFS_DIN_A    8'h00
`define PPC_OFS_DIN_B    8'h01
`define PPC_OFS_MODE_A   8'h02
`define PPC_OFS_MODE_B   8'h03
`define PPC_OFS_DOUT_A   8'h04
`define PPC_OFS_DOUT_B   8'h05
`define PPC_OFS_DIR_A    8'h06
`define PPC_OFS_DIR_B    8'h07
`define PPC_OFS_DRV_A    8'h08
`define PPC_OFS_DRV_B    8'h09
`define PPC_OFS_OEN_A    8'h0c
`define PPC_OFS_OEN_B    8'h0d
`define PPC_OFS_DIN_C    8'h10
`define PPC_OFS_DIN_D    8'h11
`define PPC_OFS_DOUT_C   8'h12
`define PPC_OFS_DOUT_D   8'h13
`define PPC_OFS_DIR_C    8'h14
`define PPC_OFS_DIR_D    8'h15
`define PPC_OFS_DRV_C    8'h16
`define PPC_OFS_DRV_D    8'h17
`define PPC_OFS_OEN_C    8'h1a
`define PPC_OFS_OEN_D    8'h1b
// Reset value of every configuration register.
`define PPC_RST_VAL      8'h00
// Field positions.
`define PPC_SLEW_MSB     3
`define PPC_OD_LSB       4
`define PPC_D_PIN_MASK   8'h06
// Port C pins given over to the serial programming interface.
`define PPC_C_PROG_MASK  8'h63
`endif

// ### pkg/ppc_pkg.sv
package ppc_pkg;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ppc_bus_t;
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] od;
      logic [7:0] fast;
   } ppc_pin_t;
endpackage

// ### core/ppc_port_cfg.sv
`timescale 1ns/1ps
`include "ppc_map.svh"
module ppc_port_cfg (
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   input  wire ppc_pkg::ppc_bus_t bus,
   output logic [7:0]            rdata,
   input  wire logic [15:0]      latched_addr,
   input  wire logic [7:0]       output_cell_bank_first,
   input  wire logic [7:0]       output_cell_bank_second,
   input  wire logic [7:0]       first_bank_to_b,
   input  wire logic [7:0]       second_bank_to_c,
   input  wire logic [7:0]       cell_sel_a,
   input  wire logic [7:0]       cell_sel_b,
   input  wire logic [7:0]       cell_sel_c,
   input  wire logic [7:0]       array_oe_a,
   input  wire logic [7:0]       array_oe_b,
   input  wire logic [7:0]       array_oe_c,
   input  wire logic [7:0]       pin_in_a,
   input  wire logic [7:0]       pin_in_b,
   input  wire logic [7:0]       pin_in_c,
   input  wire logic [7:0]       pin_in_d,
   output ppc_pkg::ppc_pin_t     port_a,
   output ppc_pkg::ppc_pin_t     port_b,
   output ppc_pkg::ppc_pin_t     port_c,
   output ppc_pkg::ppc_pin_t     port_d
);
   logic [7:0] port_mode_select [2];
   logic [7:0] pin_direction    [4];
   logic [7:0] pin_drive_select [4];
   logic [7:0] data_out         [4];
   logic [7:0] pin_s1 [4];
   logic [7:0] pin_s2 [4];
   logic [7:0] pin_s3 [4];
   logic [7:0] data_in [4];
   logic [7:0] pin_raw [4];
   logic [7:0] arr_oe [4];
   logic [7:0] cell_val [4];
   logic [7:0] cell_sel [4];
   logic [7:0] next_out [4];
   logic [7:0] next_oe [4];
   logic [7:0] next_od [4];
   logic [7:0] next_fast [4];
   logic [7:0] mask [4];

   assign pin_raw[0] = pin_in_a;
   assign pin_raw[1] = pin_in_b;
   assign pin_raw[2] = pin_in_c;
   assign pin_raw[3] = pin_in_d;
   assign arr_oe[0] = array_oe_a;
   assign arr_oe[1] = array_oe_b;
   assign arr_oe[2] = array_oe_c;
   assign arr_oe[3] = 8'h00;
   assign cell_sel[0] = cell_sel_a;
   assign cell_sel[1] = cell_sel_b;
   assign cell_sel[2] = cell_sel_c;
   assign cell_sel[3] = 8'h00;
   // A cell bank reaches a port only where its routing bit points there.
   assign cell_val[0] = output_cell_bank_first & ~first_bank_to_b;
   assign cell_val[1] = (output_cell_bank_first & first_bank_to_b)
                      | (output_cell_bank_second & ~second_bank_to_c);
   assign cell_val[2] = output_cell_bank_second & second_bank_to_c;
   assign cell_val[3] = 8'h00;
   assign mask[0] = 8'hff;
   assign mask[1] = 8'hff;
   assign mask[2] = ~`PPC_C_PROG_MASK;
   assign mask[3] = `PPC_D_PIN_MASK;

   // Register write decode, per port.
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // Pin inputs pass three flops; a level counts once stages two and three agree.
   // The third flop costs a cycle of latency but keeps a one-cycle glitch out of reads.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int p = 0; p < 4; p++) begin
            pin_s1[p]  <= 8'h00;
            pin_s2[p]  <= 8'h00;
            pin_s3[p]  <= 8'h00;
            data_in[p] <= 8'h00;
         end
      end else begin
         for (int p = 0; p < 4; p++) begin
            pin_s1[p] <= pin_raw[p];
            pin_s2[p] <= pin_s1[p];
            pin_s3[p] <= pin_s2[p];
            for (int b = 0; b < 8; b++) begin
               if (pin_s2[p][b] == pin_s3[p][b]) begin
                  data_in[p][b] <= pin_s3[p][b];
               end
            end
         end
      end
   end

   // Mode select exists for ports A and B only.
   // Ports C and D have no mode register, so writes to such offsets are dropped.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         port_mode_select[0] <= `PPC_RST_VAL;
         port_mode_select[1] <= `PPC_RST_VAL;
      end else if (bus.wr) begin
         if (hit(bus.addr, `PPC_OFS_MODE_A)) begin
            port_mode_select[0] <= bus.wdata;
         end
         if (hit(bus.addr, `PPC_OFS_MODE_B)) begin
            port_mode_select[1] <= bus.wdata;
         end
      end
   end

   // Direction, drive select and data out for all four ports.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int p = 0; p < 4; p++) begin
            pin_direction[p]    <= `PPC_RST_VAL;
            pin_drive_select[p] <= `PPC_RST_VAL;
            data_out[p]         <= `PPC_RST_VAL;
         end
      end else if (bus.wr) begin
         unique case (bus.addr)
            `PPC_OFS_DIR_A: begin
               pin_direction[0] <= bus.wdata;
            end
            `PPC_OFS_DIR_B: begin
               pin_direction[1] <= bus.wdata;
            end
            `PPC_OFS_DIR_C: begin
               pin_direction[2] <= bus.wdata;
            end
            `PPC_OFS_DIR_D: begin
               pin_direction[3] <= bus.wdata;
            end
            `PPC_OFS_DRV_A: begin
               pin_drive_select[0] <= bus.wdata;
            end
            `PPC_OFS_DRV_B: begin
               pin_drive_select[1] <= bus.wdata;
            end
            `PPC_OFS_DRV_C: begin
               pin_drive_select[2] <= bus.wdata;
            end
            `PPC_OFS_DRV_D: begin
               pin_drive_select[3] <= bus.wdata;
            end
            `PPC_OFS_DOUT_A: begin
               data_out[0] <= bus.wdata;
            end
            `PPC_OFS_DOUT_B: begin
               data_out[1] <= bus.wdata;
            end
            `PPC_OFS_DOUT_C: begin
               data_out[2] <= bus.wdata;
            end
            `PPC_OFS_DOUT_D: begin
               data_out[3] <= bus.wdata;
            end
            default: ;
         endcase
      end
   end

   // Per-pin driver logic; every bit looks only at its own pin.
   // Address mode is applied after cell selection, so it always wins.
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         for (int b = 0; b < 8; b++) begin
            next_out[p][b] = cell_sel[p][b] ? cell_val[p][b] : data_out[p][b];
            if (p < 2 && port_mode_select[p][b]) begin
               next_out[p][b] = latched_addr[p*8+b];
            end
            next_oe[p][b] = mask[p][b] & (arr_oe[p][b] | pin_direction[p][b]);
            next_od[p][b] = 1'b0;
            next_fast[p][b] = 1'b0;
         end
         if (p < 2) begin
            next_fast[p][`PPC_SLEW_MSB:0] = pin_drive_select[p][`PPC_SLEW_MSB:0];
            next_od[p][7:`PPC_OD_LSB] = pin_drive_select[p][7:`PPC_OD_LSB];
         end else if (p == 2) begin
            next_od[p] = pin_drive_select[p] & mask[p];
         end else begin
            next_fast[p] = pin_drive_select[p] & mask[p];
         end
      end
   end

   // Pin controls are registered so every output comes from a flop.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         port_a <= '0;
         port_b <= '0;
         port_c <= '0;
         port_d <= '0;
      end else begin
         port_a <= '{out: next_out[0], oe: next_oe[0], od: next_od[0], fast: next_fast[0]};
         port_b <= '{out: next_out[1], oe: next_oe[1], od: next_od[1], fast: next_fast[1]};
         port_c <= '{out: next_out[2], oe: next_oe[2], od: next_od[2], fast: next_fast[2]};
         port_d <= '{out: next_out[3], oe: next_oe[3], od: next_od[3], fast: next_fast[3]};
      end
   end

   // Read data is registered: it appears the cycle after the read strobe.
   // Enable-out reads return the registered enable, one cycle behind its inputs.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= 8'h00;
      end else if (bus.rd) begin
         unique case (bus.addr)
            `PPC_OFS_DIN_A: begin
               rdata <= data_in[0];
            end
            `PPC_OFS_DIN_B: begin
               rdata <= data_in[1];
            end
            `PPC_OFS_DIN_C: begin
               rdata <= data_in[2];
            end
            `PPC_OFS_DIN_D: begin
               rdata <= data_in[3];
            end
            `PPC_OFS_MODE_A: begin
               rdata <= port_mode_select[0];
            end
            `PPC_OFS_MODE_B: begin
               rdata <= port_mode_select[1];
            end
            `PPC_OFS_DOUT_A: begin
               rdata <= data_out[0];
            end
            `PPC_OFS_DOUT_B: begin
               rdata <= data_out[1];
            end
            `PPC_OFS_DOUT_C: begin
               rdata <= data_out[2];
            end
            `PPC_OFS_DOUT_D: begin
               rdata <= data_out[3];
            end
            `PPC_OFS_DIR_A: begin
               rdata <= pin_direction[0];
            end
            `PPC_OFS_DIR_B: begin
               rdata <= pin_direction[1];
            end
            `PPC_OFS_DIR_C: begin
               rdata <= pin_direction[2];
            end
            `PPC_OFS_DIR_D: begin
               rdata <= pin_direction[3];
            end
            `PPC_OFS_DRV_A: begin
               rdata <= pin_drive_select[0];
            end
            `PPC_OFS_DRV_B: begin
               rdata <= pin_drive_select[1];
            end
            `PPC_OFS_DRV_C: begin
               rdata <= pin_drive_select[2];
            end
            `PPC_OFS_DRV_D: begin
               rdata <= pin_drive_select[3];
            end
            `PPC_OFS_OEN_A: begin
               rdata <= port_a.oe;
            end
            `PPC_OFS_OEN_B: begin
               rdata <= port_b.oe;
            end
            `PPC_OFS_OEN_C: begin
               rdata <= port_c.oe;
            end
            `PPC_OFS_OEN_D: begin
               rdata <= port_d.oe;
            end
            default:         rdata <= 8'h00;
         endcase
      end
   end
endmodule

// ### bench/ppc_port_cfg_asserts.sv
`timescale 1ns/1ps
module ppc_port_cfg_chk (
   input wire logic              core_clk,
   input wire logic              rst_b,
   input wire ppc_pkg::ppc_bus_t bus,
   input wire logic [7:0]        rdata,
   input wire logic [7:0]        array_oe_a,
   input wire ppc_pkg::ppc_pin_t port_a,
   input wire ppc_pkg::ppc_pin_t port_c,
   input wire ppc_pkg::ppc_pin_t port_d
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // A second write right behind is excluded; it would move port_a.oe only a cycle after the check.
   sequence s_dir_wr;
      bus.wr && bus.addr == 8'h06 ##1 !bus.wr;
   endsequence
   chk_dir_to_oe: assert property (s_dir_wr |=>
      port_a.oe == ($past(bus.wdata, 2) | $past(array_oe_a))) else $error("oe after dir write");
   chk_array_oe: assert property ($past(rst_b) |->
      (port_a.oe & $past(array_oe_a)) == $past(array_oe_a)) else $error("array enable lost");
   chk_reset_zero: assert property ($rose(rst_b) |->
      (port_a.oe | port_a.od | port_c.oe | port_d.oe | rdata) == 8'h00) else $error("not clear");
   chk_unmapped_rd: assert property (bus.rd && bus.addr inside {8'h0e, 8'hff} |=>
      rdata == 8'h00) else $error("unmapped read data");
   chk_d_two_pins: assert property (((port_d.oe | port_d.fast) & 8'hf9) == 8'h00)
      else $error("port d extra pin");
   chk_ab_split: assert property (((port_a.od & 8'h0f) | (port_a.fast & 8'hf0)) == 8'h00)
      else $error("port a drive split");
   chk_prog_pins: assert property (((port_c.oe | port_c.od) & 8'h63) == 8'h00)
      else $error("programming pin used");
   chk_c_no_fast: assert property (port_c.fast == 8'h00)
      else $error("port c fast slew");
endmodule
bind ppc_port_cfg ppc_port_cfg_chk ppc_port_cfg_chk_i (.core_clk(core_clk), .rst_b(rst_b),
   .bus(bus), .rdata(rdata), .array_oe_a(array_oe_a), .port_a(port_a), .port_c(port_c),
   .port_d(port_d));

// ### bench/ppc_pin_model.sv
`timescale 1ns/1ps
module ppc_pin_model (
   input  wire ppc_pkg::ppc_pin_t drv,
   input  wire logic [7:0]        ext_val,
   output logic [7:0]             level
);
   // An open-drain high lets go of the wire, so the external pull-up wins.
   logic [7:0] held;
   logic [7:0] pulled;
   assign held = drv.oe & ~(drv.od & drv.out);
   assign pulled = drv.oe & drv.od & drv.out;
   assign level = (held & drv.out) | pulled | (~held & ~pulled & ext_val);
endmodule

// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
   logic              core_clk;
   logic              rst_b;
   ppc_pkg::ppc_bus_t bus;
   logic [7:0]        rdata;
   logic [15:0]       latched_addr;
   logic [7:0]        bank2, to_c, sel_b, sel_c, oe_a, oe_c, ext, lvl_a;
   ppc_pkg::ppc_pin_t port_a, port_b, port_c, port_d;
   int                error_cnt, compares;
   logic [7:0]        ofs [8] = '{8'h02, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h14, 8'h16};
   ppc_port_cfg ppc_port_cfg_i (.core_clk(core_clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
      .latched_addr(latched_addr), .output_cell_bank_first(8'h00),
      .output_cell_bank_second(bank2), .first_bank_to_b(8'h00), .second_bank_to_c(to_c),
      .cell_sel_a(8'h00), .cell_sel_b(sel_b), .cell_sel_c(sel_c), .array_oe_a(oe_a),
      .array_oe_b(8'h00), .array_oe_c(oe_c), .pin_in_a(lvl_a), .pin_in_b(ext), .pin_in_c(ext),
      .pin_in_d(ext), .port_a(port_a), .port_b(port_b), .port_c(port_c), .port_d(port_d));
   ppc_pin_model ppc_pin_model_i (.drv(port_a), .ext_val(ext), .level(lvl_a));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      bus = '{1'b1, 1'b0, a, d};
      @(negedge core_clk);
      bus.wr = 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      @(negedge core_clk);
      bus = '{1'b0, 1'b1, a, 8'h00};
      @(negedge core_clk);
      bus.rd = 1'b0;
      chk(rdata, e);
   endtask
   task automatic settle;
      repeat (2) @(negedge core_clk);
   endtask
   task automatic close_out;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   initial begin
      #50000;
      error_cnt++;
      close_out;
   end
   initial begin
      {rst_b, bus, bank2, to_c, sel_b, sel_c, oe_a, oe_c, ext} = '0;
      {error_cnt, compares} = '0;
      latched_addr = 16'ha55a;
      bank2 = 8'h80;
      repeat (6) @(negedge core_clk);
      rst_b = 1'b1;
      foreach (ofs[i]) wr(ofs[i], ofs[i] ^ 8'h5a);
      foreach (ofs[i]) rdc(ofs[i], ofs[i] ^ 8'h5a);
      // A reset in mid-run must wipe what was just written.
      rst_b = 1'b0;
      @(negedge core_clk);
      rst_b = 1'b1;
      foreach (ofs[i]) rdc(ofs[i], 8'h00);
      wr(8'h0e, 8'hff);
      wr(8'hff, 8'hff);
      rdc(8'h0e, 8'h00);
      rdc(8'hff, 8'h00);
      wr(8'h06, 8'h07);
      oe_a = 8'h80;
      wr(8'h04, 8'h05);
      settle;
      chk(port_a.oe, 8'h87);
      oe_a = 8'h00;
      settle;
      chk(port_a.oe, 8'h07);
      repeat (6) @(negedge core_clk);
      rdc(8'h00, 8'h05);
      rdc(8'h0c, 8'h07);
      wr(8'h08, 8'hff);
      settle;
      chk(port_a.od, 8'hf0);
      chk(port_a.fast, 8'h0f);
      wr(8'h15, 8'hff);
      wr(8'h17, 8'hff);
      oe_c = 8'hff;
      wr(8'h16, 8'hff);
      settle;
      chk(port_d.oe, 8'h06);
      chk(port_d.fast, 8'h06);
      chk(port_c.oe, 8'h9c);
      chk(port_c.od, 8'h9c);
      wr(8'h03, 8'h0f);
      {sel_c, to_c} = 16'h8080;
      settle;
      chk(port_b.out, 8'h05);
      chk(port_c.out, 8'h80);
      {sel_b, to_c} = 16'h8000;
      settle;
      chk(port_c.out, 8'h00);
      chk(port_b.out, 8'h85);
      close_out;
   end
endmodule
